// File: msru_pkg.sv
/*
  msru_pkg: constants and types for the memory sync and reservation unit.
  assumes a 32-bit effective address and a single core clock domain.
*/
package msru_pkg;
  localparam int MSRU_AW = 32;
  localparam int MSRU_GRAN_LSB = 5;
  localparam int MSRU_GW = MSRU_AW - MSRU_GRAN_LSB;
  localparam logic [1:0] MSRU_WORD_MASK = 2'h3;
  localparam logic MSRU_RSV_RST = 1'h0;
  localparam logic MSRU_FLAG_RST = 1'h0;

  typedef enum logic [1:0] {
    MSRU_B_IDLE = 2'b00,
    MSRU_B_DRAIN = 2'b01,
    MSRU_B_DONE = 2'b10
  } msru_bstate_t;
endpackage : msru_pkg

// File: msru_rsv_if.sv
/*
  msru_rsv_if: carries reservation requests from the top to the tracker.
  assumes all signals are on the core clock.
*/
`timescale 1ns/1ps
interface msru_rsv_if;
  import msru_pkg::*;
  logic lr_req;
  logic sc_req;
  logic snp_wr;
  logic [MSRU_AW-1:0] lr_addr;
  logic [MSRU_AW-1:0] snp_addr;
  logic held;
  logic sc_ok;
  logic sc_done;
  modport top (output lr_req, sc_req, snp_wr, lr_addr, snp_addr, input held, sc_ok, sc_done);
  modport trk (input lr_req, sc_req, snp_wr, lr_addr, snp_addr, output held, sc_ok, sc_done);
endinterface : msru_rsv_if

// File: msru_rsv.sv
/*
  msru_rsv: single-entry reservation tracker.
  assumes at most one load-reserve or store-conditional request per cycle.
*/
`timescale 1ns/1ps
module msru_rsv
  import msru_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  msru_rsv_if.trk rif
);
  typedef struct packed {
    logic valid;
    logic [MSRU_GW-1:0] gran;
    logic ok;
    logic done;
  } msru_rsv_st_t;

  msru_rsv_st_t st;
  msru_rsv_st_t next_st;
  logic snp_hit;

  // low address bits dropped: compare whole granules only
  assign snp_hit = rif.snp_wr && st.valid &&
    (rif.snp_addr[MSRU_AW-1:MSRU_GRAN_LSB] == st.gran); // R06 R13

  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    if (snp_hit) begin
      next_st.valid = 1'b0; // R13
    end
    if (rif.sc_req) begin
      next_st.ok = st.valid; // R07 R08 R11
      next_st.done = 1'b1;
      next_st.valid = 1'b0; // R12
    end else if (rif.lr_req) begin
      // a new reservation wins over a snoop hit on the old granule
      next_st.valid = 1'b1; // R09 R10
      next_st.gran = rif.lr_addr[MSRU_AW-1:MSRU_GRAN_LSB]; // R06 R10
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '{valid: MSRU_RSV_RST, gran: '0, ok: MSRU_FLAG_RST, done: 1'b0}; // R16
    end else begin
      st <= next_st;
    end
  end

  assign rif.held = st.valid;
  assign rif.sc_ok = st.ok;
  assign rif.sc_done = st.done;
endmodule : msru_rsv

// File: msru_top.sv
/*
  msru_top: memory barrier sequencer and reservation front end.
  assumes the pipeline reports older-instruction progress as same-clock levels
  and that the snoop bus comes from another domain, so it is synchronised here.
*/
`timescale 1ns/1ps
// Function
// R01 - barrier stalls younger instructions until older ones cannot fault
// R02 - barrier waits until older memory accesses are globally performed
// R03 - barrier never starts a bus transaction
// R04 - barrier waits for all older load/store cache and bus activity
// R05 - touch hints need only finish translation, not their bus cycle
// R06 - reservation covers one aligned 32-byte granule
// R07 - store-conditional with reservation stores and sets success flag
// R08 - store-conditional without reservation suppresses store, clears flag
// R09 - at most one reservation: one valid flag, one granule address
// R10 - each load-reserve sets valid and replaces the granule address
// R11 - store-conditional succeeds regardless of address match
// R12 - every store-conditional clears the reservation
// R13 - snooped foreign write in the granule clears the reservation
// R14 - load-reserve and store-conditional addresses must be word aligned
// R15 - write-through target never raises a storage fault here
// R16 - reservation cleared at reset
module msru_top
  import msru_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic SYNC_REQ,
  input wire logic OLDER_EXC_PEND,
  input wire logic OLDER_MEM_PEND,
  input wire logic OLDER_BUS_PEND,
  input wire logic OLDER_TOUCH_XLATE_PEND,
  input wire logic LR_REQ,
  input wire logic SC_REQ,
  input wire logic [MSRU_AW-1:0] EA,
  input wire logic WT_MEM,
  input wire logic SNP_WR,
  input wire logic [MSRU_AW-1:0] SNP_ADDR,
  output logic YOUNGER_STALL,
  output logic SYNC_DONE,
  output logic BUS_REQ,
  output logic SC_STORE_EN,
  output logic SC_DONE,
  output logic SUCCESS_FLAG,
  output logic RSV_HELD,
  output logic ALIGN_ERR,
  output logic DSI_FAULT
);
  typedef struct packed {
    msru_bstate_t bst;
    logic stall;
    logic done;
    logic snp_wr_s1;
    logic snp_wr_s2;
    logic snp_wr_s3;
    logic [MSRU_AW-1:0] snp_a_s1;
    logic [MSRU_AW-1:0] snp_a_s2;
    logic align_err;
  } msru_top_st_t;

  msru_top_st_t st;
  msru_top_st_t next_st;
  logic older_busy;
  logic misalign;

  msru_rsv_if rif ();

  msru_rsv u_rsv (
    .clk(CLK),
    .rst(RST),
    .rif(rif)
  );

  // touch hints are absent here: only their translation is waited on
  assign older_busy = OLDER_EXC_PEND || OLDER_MEM_PEND || OLDER_BUS_PEND ||
    OLDER_TOUCH_XLATE_PEND; // R01 R02 R04 R05
  assign misalign = (EA[1:0] & MSRU_WORD_MASK) != 2'h0;

  // misaligned load-reserves are flagged and not tracked: no defined granule exists; misaligned store-conditionals still reach the tracker
  assign rif.lr_req = LR_REQ && !misalign; // R14
  assign rif.sc_req = SC_REQ; // R12
  assign rif.lr_addr = EA;
  // the address word crosses bit by bit: trust it only once the strobe was seen twice,
  // so every address flop has sampled a word that was already stable
  assign rif.snp_wr = st.snp_wr_s2 && st.snp_wr_s3; // R13
  assign rif.snp_addr = st.snp_a_s2;

  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    next_st.snp_wr_s1 = SNP_WR;
    next_st.snp_wr_s2 = st.snp_wr_s1;
    next_st.snp_wr_s3 = st.snp_wr_s2;
    next_st.snp_a_s1 = SNP_ADDR;
    next_st.snp_a_s2 = st.snp_a_s1;
    next_st.align_err = (LR_REQ || SC_REQ) && misalign; // R14
    unique case (st.bst)
      MSRU_B_IDLE: begin
        if (SYNC_REQ) begin
          next_st.bst = MSRU_B_DRAIN;
          next_st.stall = 1'b1; // R01
        end
      end
      MSRU_B_DRAIN: begin
        if (!older_busy) begin
          next_st.bst = MSRU_B_DONE; // R01 R02 R04 R05
        end
      end
      MSRU_B_DONE: begin
        next_st.bst = MSRU_B_IDLE;
        next_st.stall = 1'b0;
        next_st.done = 1'b1;
      end
      default: begin
        next_st.bst = MSRU_B_IDLE;
        next_st.stall = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      YOUNGER_STALL <= 1'b0;
      SYNC_DONE <= 1'b0;
      BUS_REQ <= 1'b0;
      SC_STORE_EN <= 1'b0;
      SC_DONE <= 1'b0;
      SUCCESS_FLAG <= MSRU_FLAG_RST;
      RSV_HELD <= MSRU_RSV_RST;
      ALIGN_ERR <= 1'b0;
      DSI_FAULT <= 1'b0;
    end else begin
      YOUNGER_STALL <= next_st.stall;
      SYNC_DONE <= next_st.done;
      BUS_REQ <= 1'b0; // R03
      SC_STORE_EN <= rif.sc_done && rif.sc_ok; // R07 R08
      SC_DONE <= rif.sc_done;
      SUCCESS_FLAG <= rif.sc_done ? rif.sc_ok : SUCCESS_FLAG; // R07 R08
      RSV_HELD <= rif.held;
      ALIGN_ERR <= st.align_err;
      DSI_FAULT <= 1'b0 & WT_MEM; // R15
    end
  end
endmodule : msru_top

// File: msru_chk.sv
/* msru_chk: port assertions for msru_top.
   assumes it is bound to msru_top, one clock. */
`timescale 1ns/1ps
module msru_chk
  import msru_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic SYNC_REQ,
  input wire logic OLDER_EXC_PEND,
  input wire logic OLDER_MEM_PEND,
  input wire logic OLDER_BUS_PEND,
  input wire logic OLDER_TOUCH_XLATE_PEND,
  input wire logic LR_REQ,
  input wire logic SC_REQ,
  input wire logic [MSRU_AW-1:0] EA,
  input wire logic SNP_WR,
  input wire logic YOUNGER_STALL,
  input wire logic SYNC_DONE,
  input wire logic BUS_REQ,
  input wire logic SC_STORE_EN,
  input wire logic SC_DONE,
  input wire logic SUCCESS_FLAG,
  input wire logic RSV_HELD,
  input wire logic ALIGN_ERR
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // a recent lr or snoop leaves the held level stale for a few cycles
  logic [2:0] busy;
  wire pend = OLDER_EXC_PEND | OLDER_MEM_PEND | OLDER_BUS_PEND | OLDER_TOUCH_XLATE_PEND;
  wire ok = busy == 3'h0 && !LR_REQ && EA[1:0] == 2'h0;
  always_ff @(posedge CLK) busy <= {busy[1:0], SNP_WR | LR_REQ};
  sequence s_win; SC_REQ && ok && RSV_HELD; endsequence
  sequence s_paid; SC_DONE && SUCCESS_FLAG && SC_STORE_EN && !RSV_HELD; endsequence
  property p_bus; BUS_REQ == 1'h0; endproperty
  a_bus: assert property (p_bus) else $error("bus");
  property p_stall; SYNC_REQ && !YOUNGER_STALL |=> YOUNGER_STALL; endproperty
  a_stall: assert property (p_stall) else $error("stall");
  property p_hold; YOUNGER_STALL && pend && $past(pend) |=> YOUNGER_STALL; endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_done; SYNC_DONE |-> !YOUNGER_STALL && !$past(pend, 2); endproperty
  a_done: assert property (p_done) else $error("done");
  property p_scok; s_win |-> ##2 s_paid; endproperty
  a_scok: assert property (p_scok) else $error("scok");
  property p_scno; SC_REQ && ok && !RSV_HELD |-> ##2 SC_DONE && !SC_STORE_EN; endproperty
  a_scno: assert property (p_scno) else $error("scno");
  property p_lr; LR_REQ && !SC_REQ && EA[1:0] == 2'h0 |-> ##2 RSV_HELD; endproperty
  a_lr: assert property (p_lr) else $error("lr");
  property p_aln; (LR_REQ || SC_REQ) && EA[1:0] != 2'h0 |-> ##2 ALIGN_ERR; endproperty
  a_aln: assert property (p_aln) else $error("aln");
endmodule : msru_chk

// File: msru_snp.sv
/* msru_snp: another bus master whose writes are snooped.
   assumes it is called just after a clock edge. */
`timescale 1ns/1ps
module msru_snp
  import msru_pkg::*;
(
  input wire logic CLK,
  output logic SNP_WR,
  output logic [MSRU_AW-1:0] SNP_ADDR
);
  initial SNP_WR = 1'h0;
  initial SNP_ADDR = 32'h5a5a5a5a;
  // released address flips so a stale value never looks live
  task wr(input logic [MSRU_AW-1:0] a, input int n);
    SNP_ADDR = a;
    SNP_WR = 1'h1;
    repeat (n) @(posedge CLK);
    #1;
    SNP_WR = 1'h0;
    SNP_ADDR = ~a;
  endtask : wr
endmodule : msru_snp

// File: msru_tb.sv
/* tb: scenarios for msru_top with a snoop master.
   assumes msru_chk and msru_snp are compiled first. */
`timescale 1ns/1ps
bind msru_top msru_chk msru_chk_inst(.*);
module tb;
  import msru_pkg::*;
  logic CLK = 0, RST = 1, SYNC_REQ = 0, LR_REQ = 0, SC_REQ = 0, WT_MEM = 0;
  logic [3:0] pend = 4'h0;
  wire OLDER_EXC_PEND = pend[0], OLDER_MEM_PEND = pend[1];
  wire OLDER_BUS_PEND = pend[2], OLDER_TOUCH_XLATE_PEND = pend[3];
  logic [MSRU_AW-1:0] EA = 32'h0, SNP_ADDR;
  logic SNP_WR, YOUNGER_STALL, SYNC_DONE, BUS_REQ, SC_STORE_EN, SC_DONE;
  logic SUCCESS_FLAG, RSV_HELD, ALIGN_ERR, DSI_FAULT;
  int n_errors = 0, compares = 0;
  msru_top msru_top_inst(.*);
  msru_snp msru_snp_inst(.*);
  initial forever #5 CLK = ~CLK;
  task cyc(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask : cyc
  task chk(input string nm, input logic e, input logic s);
    compares++;
    if (s !== e) begin
      n_errors++;
      $display("[FAIL] %s exp %b got %b", nm, e, s);
    end
  endtask : chk
  task op(input logic lr, input logic [MSRU_AW-1:0] a);
    LR_REQ = lr;
    SC_REQ = !lr;
    EA = a;
    cyc(1);
    LR_REQ = 0;
    SC_REQ = 0;
    cyc(1);
  endtask : op
  task test_done;
    if (n_errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done
  task t_sc;
    op(0, 32'h40);
    chk("flag", 0, SUCCESS_FLAG);
    chk("store", 0, SC_STORE_EN);
    chk("scdone", 1, SC_DONE);
    op(1, 32'h100);
    chk("held", 1, RSV_HELD);
    op(0, 32'h244);
    chk("flag", 1, SUCCESS_FLAG);
    chk("store", 1, SC_STORE_EN);
    chk("scdone", 1, SC_DONE);
    chk("held", 0, RSV_HELD);
    op(0, 32'h100);
    chk("flag", 0, SUCCESS_FLAG);
  endtask : t_sc
  task t_snp(input logic [MSRU_AW-1:0] la, input logic [MSRU_AW-1:0] sa, input logic e);
    op(1, la);
    msru_snp_inst.wr(sa, 3 + e * 2);
    cyc(3);
    chk("snp", e, RSV_HELD);
  endtask : t_snp
  task t_sync;
    int i, w;
    for (i = 0; i < 4; i++) begin
      pend = 4'h1 << i;
      SYNC_REQ = 1;
      cyc(1);
      SYNC_REQ = 0;
      cyc(6);
      chk("stall", 1, YOUNGER_STALL);
      chk("bus", 0, BUS_REQ);
      pend = 4'h0;
      w = 0;
      while (SYNC_DONE !== 1'h1 && w < 4) begin
        cyc(1);
        w++;
      end
      chk("done", 1, SYNC_DONE);
      chk("free", 0, YOUNGER_STALL);
      cyc(1);
    end
  endtask : t_sync
  task t_aln;
    WT_MEM = 1;
    op(0, 32'h0);
    chk("flag", 1, SUCCESS_FLAG);
    op(1, 32'h3002);
    chk("aln", 1, ALIGN_ERR);
    chk("held", 0, RSV_HELD);
    chk("dsi", 0, DSI_FAULT);
    op(0, 32'h3006);
    chk("aln", 1, ALIGN_ERR);
    chk("flag", 0, SUCCESS_FLAG);
  endtask : t_aln
  task t_rst;
    op(1, 32'h100);
    RST = 1;
    cyc(2);
    RST = 0;
    cyc(1);
    chk("rst", 0, RSV_HELD);
    op(0, 32'h40);
    chk("flag", 0, SUCCESS_FLAG);
  endtask : t_rst
  initial begin
    cyc(8);
    RST = 0;
    t_sc();
    t_snp(32'h1000, 32'h101c, 0);
    t_snp(32'h1000, 32'h1020, 1);
    t_snp(32'h1000, 32'h0ffc, 1);
    op(1, 32'h1000);
    t_snp(32'h2004, 32'h1000, 1);
    t_aln();
    t_sync();
    t_rst();
    test_done();
  end
  initial begin
    #20000;
    n_errors++;
    test_done();
  end
endmodule : tb
